// [verilog/counter_defines.svh]
// Offsets, field positions, reset values and codes of the event counter
`ifndef COUNTER_DEFINES_SVH
`define COUNTER_DEFINES_SVH
`define REG_CTRL 8'h00
`define REG_PRESET 8'h04
`define REG_LIMIT 8'h08
`define REG_COUNT 8'h0C
`define REG_STATUS 8'h10
`define REG_DIAG 8'h14
`define REG_MSG 8'h18
`define REG_IRQ_STAT 8'h1C
`define REG_IRQ_CLR 8'h20
`define REG_IRQ_EN 8'h24
`define REG_FBNUM 8'h28
`define CTRL_RUN 0
`define CTRL_SIGNED 1
`define CTRL_WIDE 2
`define CTRL_RESET 8'h00
`define PRESET_RESET 32'h0000_0000
`define LIMIT_RESET 32'h0000_0000
`define DIAG_NONE 2'h0
`define DIAG_UNDER 2'h1
`define DIAG_OVER 2'h2
`define MSG_UNDER 16'h40B8
`define MSG_OVER 16'h40B9
`define STATE_RUN 3'h1
`define STATE_STOP 3'h2
`define STATE_ERROR 3'h4
`define STATE_RESET 3'h5
`define IRQ_UNDER 0
`define IRQ_OVER 1
`define IRQ_LIMIT 2
`define IRQ_ZERO 3
`define FB_NUMBER_DEFAULT 16'h0001
`endif

// [verilog/counter_pkg.sv]
// Types shared by the event counter files
package counter_pkg;
   typedef enum logic [3:0] {
      ST_RUN = 4'b0001,
      ST_STOP = 4'b0010,
      ST_ERROR = 4'b0100,
      ST_RESET = 4'b1000
   } fb_state_t;
   typedef logic [1:0] diag_t;
endpackage

// [verilog/edge_sync.sv]
// Two-stage synchroniser with rising edge detect for one pin
`timescale 1ns/100ps
module edge_sync (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic pin_i,
   input wire logic clear_i,
   output logic level_o,
   output logic rise_o
);
   logic meta;
   logic prev;

   // Synchroniser and previous sample
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta <= 1'b0;
         level_o <= 1'b0;
         prev <= 1'b0;
      end else begin
         meta <= pin_i;
         level_o <= meta;
         // Clear masks the next edge by faking a high last sample
         prev <= level_o | clear_i;
      end
   end

   // Rise when sampled level high and last sample low
   assign rise_o = level_o & ~prev;
endmodule

// [verilog/event_counter.sv]
// Up/down event counter block with Wishbone registers and interrupt
`timescale 1ns/100ps
`include "counter_defines.svh"

// Summary of operation
// - Reset input high loads preset value
// - Increment rising edge adds one
// - Decrement rising edge subtracts one
// - Both edges together leave count unchanged
// - Reset wins; step at most one
// - Running: limit flag when count >= limit
// - Running: zero flag at zero, error low
// - Group start loads preset value
// - Group stopped forces count zero
// - Run enable low: stop state 2, zeros
// - Count signed/unsigned, 16 or 32 bits
// - Underflow: diag 1, message 0x40B8
// - Overflow: diag 2, message 0x40B9
// - Running state reports value 1
// - Range error: state 4, error high
// - Error gone plus acknowledge: state 5
module event_counter #(
   parameter logic [15:0] FB_NUMBER = `FB_NUMBER_DEFAULT
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_we_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic count_reset_i,
   input wire logic increment_request_i,
   input wire logic decrement_request_i,
   input wire logic group_run_i,
   input wire logic group_error_acknowledge_i,
   output logic error_o,
   output logic limit_reached_flag_o,
   output logic zero_reached_flag_o,
   output logic [31:0] current_count_o,
   output logic [2:0] state_o,
   output logic [1:0] diag_o,
   output logic diag_msg_valid_o,
   output logic [15:0] diag_msg_id_o,
   output logic [31:0] diag_msg_value_o,
   output logic [31:0] diag_msg_bound_o,
   output logic irq_o
);
   import counter_pkg::*;

   logic [7:0] ctrl;
   logic [31:0] preset;
   logic [31:0] limit;
   logic [3:0] irq_stat;
   logic [3:0] irq_en;
   fb_state_t state;
   logic [31:0] count;
   diag_t diag;
   logic group_run_d;
   logic reset_lvl;
   logic run_lvl;
   logic ack_lvl;
   logic inc_rise;
   logic dec_rise;
   logic block_run_enable;
   logic signed_mode;
   logic wide_mode;
   logic [31:0] next_count;
   logic under;
   logic over;
   logic range_err;
   logic limit_hit;
   logic zero_hit;
   logic limit_hit_d;
   logic zero_hit_d;
   logic wb_req;
   logic [3:0] irq_clr;
   logic [31:0] rd_data;

   // Masks a value to the configured width
   function automatic logic [31:0] fit(input logic [31:0] v,
                                       input logic wide);
      fit = wide ? v : {16'h0000, v[15:0]};
   endfunction

   // Smallest value of the configured type
   function automatic logic [31:0] type_min(input logic sgn,
                                            input logic wide);
      if (!sgn)
         type_min = 32'h0000_0000;
      else if (wide)
         type_min = 32'h8000_0000;
      else
         type_min = 32'h0000_8000;
   endfunction

   // Largest value of the configured type
   function automatic logic [31:0] type_max(input logic sgn,
                                            input logic wide);
      if (wide)
         type_max = sgn ? 32'h7FFF_FFFF : 32'hFFFF_FFFF;
      else
         type_max = sgn ? 32'h0000_7FFF : 32'h0000_FFFF;
   endfunction

   // Level inputs synchronised; only group run also used for its rising edge
   logic [2:0] meta_lvl;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta_lvl <= 3'h0;
         reset_lvl <= 1'b0;
         run_lvl <= 1'b0;
         ack_lvl <= 1'b0;
      end else begin
         meta_lvl <= {group_error_acknowledge_i, group_run_i,
                      count_reset_i};
         reset_lvl <= meta_lvl[0];
         run_lvl <= meta_lvl[1];
         ack_lvl <= meta_lvl[2];
      end
   end

   edge_sync inc_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .pin_i(increment_request_i),
      .clear_i(1'b0),
      .level_o(),
      .rise_o(inc_rise)
   );
   edge_sync dec_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .pin_i(decrement_request_i),
      .clear_i(1'b0),
      .level_o(),
      .rise_o(dec_rise)
   );

   assign block_run_enable = ctrl[`CTRL_RUN];
   assign signed_mode = ctrl[`CTRL_SIGNED];
   assign wide_mode = ctrl[`CTRL_WIDE];

   // Range check of one step
   always_comb begin
      under = 1'b0;
      over = 1'b0;
      next_count = count;
      if (inc_rise && !dec_rise) begin
         if (count == type_max(signed_mode, wide_mode))
            over = 1'b1;
         else
            next_count = fit(count + 32'h0000_0001, wide_mode);
      end else if (dec_rise && !inc_rise) begin
         if (count == type_min(signed_mode, wide_mode))
            under = 1'b1;
         else
            next_count = fit(count - 32'h0000_0001, wide_mode);
      end
   end
   assign range_err = (under | over) & ~reset_lvl;

   always_comb begin
      if (signed_mode && wide_mode)
         limit_hit = $signed(count) >= $signed(limit);
      else if (signed_mode)
         limit_hit = $signed(count[15:0]) >= $signed(limit[15:0]);
      else
         limit_hit = fit(count, wide_mode) >= fit(limit, wide_mode);
   end
   assign zero_hit = (count == 32'h0000_0000);

   // Block state machine
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= ST_STOP;
         group_run_d <= 1'b0;
      end else begin
         group_run_d <= run_lvl;
         unique case (state)
            ST_RUN: begin
               if (!block_run_enable || !run_lvl)
                  state <= ST_STOP;
               else if (range_err)
                  state <= ST_ERROR;
            end
            ST_STOP: begin
               if (block_run_enable && run_lvl)
                  state <= ST_RUN;
            end
            ST_ERROR: begin
               if (ack_lvl)
                  state <= ST_RESET;
            end
            ST_RESET: begin
               if (!ack_lvl)
                  state <= block_run_enable && run_lvl ? ST_RUN : ST_STOP;
            end
         endcase
      end
   end

   // Count register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         count <= 32'h0000_0000;
      end else if (state != ST_RUN) begin
         if (block_run_enable && run_lvl && state == ST_STOP)
            count <= fit(preset, wide_mode);
         else
            count <= 32'h0000_0000;
      end else if (!block_run_enable || !run_lvl) begin
         count <= 32'h0000_0000;
      end else if (run_lvl && !group_run_d) begin
         count <= fit(preset, wide_mode);
      end else if (reset_lvl) begin
         count <= fit(preset, wide_mode);
      end else if (range_err) begin
         count <= 32'h0000_0000;
      end else begin
         count <= next_count;
      end
   end

   // Diagnostic code and message
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         diag <= `DIAG_NONE;
         diag_msg_valid_o <= 1'b0;
         diag_msg_id_o <= 16'h0000;
         diag_msg_value_o <= 32'h0000_0000;
         diag_msg_bound_o <= 32'h0000_0000;
      end else begin
         diag_msg_valid_o <= 1'b0;
         if (state == ST_RUN && block_run_enable && run_lvl &&
             group_run_d && range_err) begin
            diag_msg_valid_o <= 1'b1;
            diag_msg_value_o <= count;
            if (under) begin
               diag <= `DIAG_UNDER;
               diag_msg_id_o <= `MSG_UNDER;
               diag_msg_bound_o <= type_min(signed_mode, wide_mode);
            end else begin
               diag <= `DIAG_OVER;
               diag_msg_id_o <= `MSG_OVER;
               diag_msg_bound_o <= type_max(signed_mode, wide_mode);
            end
         end else if (state == ST_RESET) begin
            diag <= `DIAG_NONE;
         end
      end
   end

   // Registered block outputs
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         error_o <= 1'b0;
         limit_reached_flag_o <= 1'b0;
         zero_reached_flag_o <= 1'b0;
         current_count_o <= 32'h0000_0000;
         state_o <= `STATE_STOP;
         diag_o <= `DIAG_NONE;
      end else begin
         diag_o <= diag;
         error_o <= (state == ST_ERROR);
         unique case (state)
            ST_RUN: state_o <= `STATE_RUN;
            ST_STOP: state_o <= `STATE_STOP;
            ST_ERROR: state_o <= `STATE_ERROR;
            ST_RESET: state_o <= `STATE_RESET;
         endcase
         limit_reached_flag_o <= (state == ST_RUN) & limit_hit;
         zero_reached_flag_o <= (state == ST_RUN) & zero_hit;
         current_count_o <= (state == ST_RUN) ? count : 32'h0000_0000;
      end
   end

   // Wishbone slave, one wait state
   assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign irq_clr = (wb_req && wb_we_i && wb_adr_i == `REG_IRQ_CLR &&
                     wb_sel_i[0]) ? wb_dat_i[3:0] : 4'h0;

   // Writable registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl <= `CTRL_RESET;
         preset <= `PRESET_RESET;
         limit <= `LIMIT_RESET;
         irq_en <= 4'h0;
      end else if (wb_req && wb_we_i) begin
         if (wb_adr_i == `REG_CTRL && wb_sel_i[0])
            ctrl <= wb_dat_i[7:0];
         if (wb_adr_i == `REG_IRQ_EN && wb_sel_i[0])
            irq_en <= wb_dat_i[3:0];
         for (int b = 0; b < 4; b++) begin
            if (wb_sel_i[b] && wb_adr_i == `REG_PRESET)
               preset[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
            if (wb_sel_i[b] && wb_adr_i == `REG_LIMIT)
               limit[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
         end
      end
   end

   // Sticky events, set wins over clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_stat <= 4'h0;
         limit_hit_d <= 1'b0;
         zero_hit_d <= 1'b0;
         irq_o <= 1'b0;
      end else begin
         limit_hit_d <= limit_reached_flag_o;
         zero_hit_d <= zero_reached_flag_o;
         irq_stat <= (irq_stat & ~irq_clr) |
                     {zero_reached_flag_o & ~zero_hit_d,
                      limit_reached_flag_o & ~limit_hit_d,
                      diag_msg_valid_o & (diag_msg_id_o == `MSG_OVER),
                      diag_msg_valid_o & (diag_msg_id_o == `MSG_UNDER)};
         irq_o <= |(irq_stat & irq_en);
      end
   end

   // Read multiplexer
   always_comb begin
      unique case (wb_adr_i)
         `REG_CTRL: rd_data = {24'h00_0000, ctrl};
         `REG_PRESET: rd_data = preset;
         `REG_LIMIT: rd_data = limit;
         `REG_COUNT: rd_data = current_count_o;
         `REG_STATUS: rd_data = {26'h000_0000, zero_reached_flag_o,
                                 limit_reached_flag_o, error_o, state_o};
         `REG_DIAG: rd_data = {30'h0000_0000, diag_o};
         `REG_MSG: rd_data = {16'h0000, diag_msg_id_o};
         `REG_IRQ_STAT: rd_data = {28'h000_0000, irq_stat};
         `REG_IRQ_EN: rd_data = {28'h000_0000, irq_en};
         `REG_FBNUM: rd_data = {16'h0000, FB_NUMBER};
         default: rd_data = 32'h0000_0000;
      endcase
   end

   // Acknowledge and read data
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= wb_req;
         wb_dat_o <= wb_req ? rd_data : 32'h0000_0000;
      end
   end
endmodule

// [tb/event_counter_properties.sv]
// Concurrent checks on the event counter ports
`timescale 1ns/100ps
`include "counter_defines.svh"
module event_counter_properties (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic error_o,
   input wire logic limit_reached_flag_o,
   input wire logic zero_reached_flag_o,
   input wire logic [31:0] current_count_o,
   input wire logic [2:0] state_o,
   input wire logic [1:0] diag_o,
   input wire logic diag_msg_valid_o,
   input wire logic [15:0] diag_msg_id_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // Error, flag and count outputs quiet
   sequence s_quiet;
      !error_o && !limit_reached_flag_o && !zero_reached_flag_o &&
      current_count_o == 32'h0000_0000;
   endsequence
   // Error state just left
   sequence s_err_left;
      state_o == `STATE_ERROR ##1 state_o != `STATE_ERROR;
   endsequence
   property p_stop;
      state_o == `STATE_STOP |-> s_quiet;
   endproperty
   a_stop: assert property (p_stop)
      else $error("stop state outputs not zero");
   property p_error;
      state_o == `STATE_ERROR |-> error_o && !limit_reached_flag_o &&
         !zero_reached_flag_o && current_count_o == 32'h0000_0000;
   endproperty
   a_error: assert property (p_error)
      else $error("error state outputs wrong");
   property p_reset_state;
      state_o == `STATE_RESET |-> s_quiet;
   endproperty
   a_reset_state: assert property (p_reset_state)
      else $error("reset state outputs not zero");
   property p_zero;
      state_o == `STATE_RUN |-> !error_o &&
         zero_reached_flag_o == (current_count_o == 32'h0000_0000);
   endproperty
   a_zero: assert property (p_zero)
      else $error("zero flag or error wrong in run");
   property p_err_exit;
      s_err_left |-> state_o == `STATE_RESET;
   endproperty
   a_err_exit: assert property (p_err_exit)
      else $error("error state left other than to reset");
   property p_msg;
      diag_msg_valid_o |-> ##[0:2] state_o == `STATE_ERROR;
   endproperty
   a_msg: assert property (p_msg)
      else $error("message without error state");
   property p_msg_under;
      diag_msg_valid_o && diag_msg_id_o == `MSG_UNDER
         |-> ##[0:2] diag_o == `DIAG_UNDER;
   endproperty
   a_msg_under: assert property (p_msg_under)
      else $error("underflow message without code");
   property p_msg_over;
      diag_msg_valid_o && diag_msg_id_o == `MSG_OVER
         |-> ##[0:2] diag_o == `DIAG_OVER;
   endproperty
   a_msg_over: assert property (p_msg_over)
      else $error("overflow message without code");
   property p_ack;
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
   endproperty
   a_ack: assert property (p_ack)
      else $error("bus answer not a one cycle pulse");
endmodule

// [tb/group_peer.sv]
// Model of the logic and group controller driving the counter pins
`timescale 1ns/100ps
module group_peer (
   input wire logic clk_i,
   output logic reset_o,
   output logic up_o,
   output logic down_o,
   output logic run_o,
   output logic ack_o
);
   // Idle levels at start
   initial begin
      {reset_o, up_o, down_o, run_o, ack_o} = 5'h00;
   end
   task automatic set(input logic r, input logic g, input logic a);
      @(posedge clk_i);
      reset_o <= r;
      run_o <= g;
      ack_o <= a;
   endtask
   // Pulse long enough to pass the input synchronisers
   task automatic pulse(input logic u, input logic d);
      @(posedge clk_i);
      up_o <= u;
      down_o <= d;
      repeat (5) @(posedge clk_i);
      up_o <= 1'b0;
      down_o <= 1'b0;
      repeat (6) @(posedge clk_i);
   endtask
endmodule

// [tb/testbench.sv]
// Directed testbench of the event counter
`timescale 1ns/100ps
`include "counter_defines.svh"
`define CHK(a, b) \
   begin \
      tests_run++; \
      if ((a) !== (b)) begin \
         n_fail++; \
         $display("FAIL %0t: got %h want %h", $time, (a), (b)); \
      end \
   end
module testbench;
   logic clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, irq_o;
   logic error_o, limit_reached_flag_o, zero_reached_flag_o;
   logic count_reset_i, increment_request_i, decrement_request_i;
   logic group_run_i, group_error_acknowledge_i;
   logic [7:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, current_count_o, rd;
   logic [2:0] state_o;
   logic [1:0] diag_o;
   logic msg_valid;
   logic [31:0] msg_value, msg_bound, msg_value_q, msg_bound_q;
   int n_fail, tests_run;
   event_counter DUT (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_sel_i,
      .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .count_reset_i,
      .increment_request_i, .decrement_request_i, .group_run_i,
      .group_error_acknowledge_i, .error_o, .limit_reached_flag_o,
      .zero_reached_flag_o, .current_count_o, .state_o, .diag_o,
      .diag_msg_valid_o(msg_valid), .diag_msg_id_o(),
      .diag_msg_value_o(msg_value), .diag_msg_bound_o(msg_bound), .irq_o);
   // Keep the payload of the last one-cycle message
   always @(posedge clk_i) begin
      if (msg_valid === 1'b1) begin
         msg_value_q <= msg_value;
         msg_bound_q <= msg_bound;
      end
   end
   group_peer peer (.clk_i, .reset_o(count_reset_i),
      .up_o(increment_request_i), .down_o(decrement_request_i),
      .run_o(group_run_i), .ack_o(group_error_acknowledge_i));
   // Clock and time zero values
   initial begin
      {clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i} = 5'h08;
      {wb_adr_i, wb_sel_i, wb_dat_i} = 44'h0;
      {n_fail, tests_run} = 0;
      forever #5 clk_i = ~clk_i;
   end
   // Classic single Wishbone cycle, answer taken at the ack edge
   task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int n;
      n = 0;
      wb_adr_i <= a;
      wb_we_i <= w;
      wb_dat_i <= d;
      wb_sel_i <= 4'hF;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1 && n < 50) begin
         @(posedge clk_i);
         n++;
      end
      if (wb_ack_o !== 1'b1) begin
         n_fail++;
         $display("FAIL %0t: bus answer missing", $time);
      end
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task automatic print_verdict;
      $display("Checks %0d, mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // Hang guard
   initial begin
      settle(20000);
      n_fail++;
      print_verdict;
   end
   // Main sequence
   initial begin
      settle(20);
      rst_i <= 1'b0;
      @(posedge clk_i);
      wb(`REG_STATUS, 0, 0);
      `CHK(rd, 32'h0000_0002)
      wb(`REG_FBNUM, 0, 0);
      `CHK(rd, {16'h0000, `FB_NUMBER_DEFAULT})
      wb(8'h3C, 0, 0);
      `CHK(rd, 32'h0000_0000)
      wb(`REG_PRESET, 1, 32'h0000_0002);
      wb(`REG_LIMIT, 1, 32'h0000_0003);
      wb(`REG_IRQ_EN, 1, 32'h0000_000F);
      wb(`REG_CTRL, 1, 32'h0000_0001);
      peer.set(0, 1, 0);
      settle(10);
      `CHK({state_o, current_count_o}, {`STATE_RUN, 32'h0000_0002})
      peer.pulse(1, 0);
      `CHK({limit_reached_flag_o, current_count_o}, 33'h1_0000_0003)
      `CHK(irq_o, 1'b1)
      wb(`REG_IRQ_STAT, 0, 0);
      `CHK(rd[`IRQ_LIMIT], 1'b1)
      wb(`REG_IRQ_CLR, 1, 32'h0000_000F);
      settle(2);
      `CHK(irq_o, 1'b0)
      peer.pulse(1, 1);
      `CHK(current_count_o, 32'h0000_0003)
      peer.set(1, 1, 0);
      peer.pulse(1, 0);
      `CHK(current_count_o, 32'h0000_0002)
      peer.set(0, 1, 0);
      settle(6);
      peer.pulse(0, 1);
      `CHK({limit_reached_flag_o, current_count_o}, 33'h0_0000_0001)
      peer.pulse(0, 1);
      `CHK({zero_reached_flag_o, current_count_o}, 33'h1_0000_0000)
      wb(`REG_IRQ_EN, 1, 32'h0000_0000);
      wb(`REG_IRQ_CLR, 1, 32'h0000_000F);
      peer.pulse(0, 1);
      `CHK({error_o, state_o, diag_o}, {1'b1, `STATE_ERROR, `DIAG_UNDER})
      wb(`REG_MSG, 0, 0);
      `CHK(rd[15:0], `MSG_UNDER)
      `CHK({msg_value_q, msg_bound_q}, 64'h0000_0000_0000_0000)
      `CHK(irq_o, 1'b0)
      wb(`REG_IRQ_STAT, 0, 0);
      `CHK(rd[`IRQ_UNDER], 1'b1)
      wb(`REG_IRQ_EN, 1, 32'h0000_000F);
      settle(2);
      `CHK(irq_o, 1'b1)
      wb(`REG_IRQ_CLR, 1, 32'h0000_000F);
      settle(2);
      `CHK(irq_o, 1'b0)
      peer.set(0, 1, 1);
      settle(8);
      `CHK({state_o, error_o, diag_o}, {`STATE_RESET, 3'h0})
      peer.set(0, 1, 0);
      settle(8);
      `CHK(state_o, `STATE_RUN)
      wb(`REG_CTRL, 1, 32'h0000_0000);
      settle(4);
      `CHK({state_o, current_count_o}, {`STATE_STOP, 32'h0})
      wb(`REG_PRESET, 1, 32'h7FFF_FFFF);
      wb(`REG_CTRL, 1, 32'h0000_0007);
      settle(8);
      `CHK(current_count_o, 32'h7FFF_FFFF)
      peer.pulse(1, 0);
      `CHK({state_o, diag_o}, {`STATE_ERROR, `DIAG_OVER})
      wb(`REG_MSG, 0, 0);
      `CHK(rd[15:0], `MSG_OVER)
      `CHK({msg_value_q, msg_bound_q}, 64'h7FFF_FFFF_7FFF_FFFF)
      peer.set(0, 1, 1);
      settle(8);
      peer.set(0, 0, 0);
      settle(8);
      `CHK({state_o, current_count_o}, {`STATE_STOP, 32'h0})
      // Signed 16-bit underflow at the type minimum
      wb(`REG_PRESET, 1, 32'h0000_8000);
      wb(`REG_CTRL, 1, 32'h0000_0003);
      peer.set(0, 1, 0);
      settle(8);
      `CHK(current_count_o, 32'h0000_8000)
      peer.pulse(0, 1);
      `CHK({state_o, diag_o}, {`STATE_ERROR, `DIAG_UNDER})
      `CHK({msg_value_q, msg_bound_q}, 64'h0000_8000_0000_8000)
      peer.set(0, 1, 1);
      settle(8);
      peer.set(0, 0, 0);
      settle(8);
      // Unsigned 32-bit overflow at the type maximum
      wb(`REG_PRESET, 1, 32'hFFFF_FFFF);
      wb(`REG_CTRL, 1, 32'h0000_0005);
      peer.set(0, 1, 0);
      settle(8);
      `CHK(current_count_o, 32'hFFFF_FFFF)
      peer.pulse(1, 0);
      `CHK({state_o, diag_o}, {`STATE_ERROR, `DIAG_OVER})
      `CHK({msg_value_q, msg_bound_q}, 64'hFFFF_FFFF_FFFF_FFFF)
      print_verdict;
   end
endmodule
bind event_counter event_counter_properties props (.clk_i, .rst_i,
   .wb_cyc_i, .wb_stb_i, .wb_ack_o, .error_o, .limit_reached_flag_o,
   .zero_reached_flag_o, .current_count_o, .state_o, .diag_o,
   .diag_msg_valid_o, .diag_msg_id_o);
